// *** design/udb_bridge.sv ***
// Bridge logic around the USB device core: endpoint buffers, resets,
// main event interrupt and resume interrupt.
// Assumes one 10 MHz clock; pins are synchronised here; software keeps
// to the bring-up order and serves transfers as intended.
`timescale 1ns/1ns
module udb_bridge
  import udb_pkg::*;
#(
  parameter int NUM_EP     = NUM_EP_DEF,
  parameter int IRQ_N      = IRQ_N_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int MAX_PKT    = MAX_PKT_DEF
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Core register port
  input  wire udb_pkg::udb_req_s regReq,
  output udb_pkg::udb_rsp_s      regRsp,
  // Direct buffer path for master transfers
  input  wire udb_pkg::udb_dir_s dirReq,
  output logic [udb_pkg::PORT_W-1:0] dirRdata,
  // Events from the device core
  input  wire logic [IRQ_N-1:0]  irqEvent,
  // Pins from other domains
  input  wire logic              busClkOn,
  input  wire logic              suspendRelease,
  input  wire logic              busPowerPresent,
  // Interrupts and channel resets
  output logic                   mainEventIrq,
  output logic                   resumeIrq,
  output logic                   wrChanRst,
  output logic                   rdChanRst
);

  logic [2:0]        sync1_q, sync2_q;
  logic [IRQ_N-1:0]  sts_q, sts_d, en_q, en_d;
  logic              wakeEn_q, wakeEn_d, softRst_q, softRst_d;
  logic              wrRst_q, wrRst_d, rdRst_q, rdRst_d;
  logic [NUM_EP-1:0] busSel_q, busSel_d, dual_q, dual_d;
  logic              resume_q, resume_d, resIrq_q, resIrq_d;
  logic              mainIrq_q, mainIrq_d;
  udb_rsp_s          rsp_q, rsp_d;
  logic [PORT_W-1:0] dirRd_q, dirRd_d;

  logic [1:0]        grp;
  logic [EP_W-1:0]   epIdx;
  logic              epOk, dirOk;
  logic [NUM_EP-1:0] fWr, fRd;
  logic [CNT_W-1:0]  byteCnt [NUM_EP];
  logic [PORT_W-1:0] rdWord  [NUM_EP];

  // Address decode
  assign grp   = regReq.addr[GRP_MSB:GRP_LSB];
  assign epIdx = regReq.addr[EPI_MSB:EPI_LSB];
  assign epOk  = int'(epIdx) < NUM_EP;
  assign dirOk = int'(dirReq.ep) < NUM_EP;

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= {busPowerPresent, suspendRelease, busClkOn};
      sync2_q <= sync1_q;
    end
  end

  // Endpoint buffers with their access path select
  for (genvar e = 0; e < NUM_EP; e++)
  begin : g_ep
    assign fWr[e] = busSel_q[e] ?
      (dirReq.wr && dirReq.ep == EP_W'(e)) :
      (regReq.req && regReq.wr && grp == GRP_FIFO && epIdx == EP_W'(e));
    assign fRd[e] = busSel_q[e] ?
      (dirReq.rd && dirReq.ep == EP_W'(e)) :
      (regReq.req && !regReq.wr && grp == GRP_FIFO && epIdx == EP_W'(e));

    udb_ep_buf #(
      .DEPTH   (FIFO_DEPTH),
      .MAX_PKT (MAX_PKT)
    ) u_buf (
      .core_clk  (core_clk),
      .srst      (srst),
      .clr       (softRst_q),
      .dualMode  (dual_q[e]),
      .wrEn      (fWr[e]),
      .wrData    (busSel_q[e] ? dirReq.wdata : regReq.wdata[PORT_W-1:0]),
      .rdEn      (fRd[e]),
      .rdData    (rdWord[e]),
      .byteCount (byteCnt[e])
    );
  end

  // Register port, interrupt status and resume logic
  always_comb
  begin
    sts_d     = sts_q;
    en_d      = en_q;
    wakeEn_d  = wakeEn_q;
    softRst_d = 1'b0;
    wrRst_d   = 1'b0;
    rdRst_d   = 1'b0;
    busSel_d  = busSel_q;
    dual_d    = dual_q;
    rsp_d     = '0;
    dirRd_d   = dirRd_q;
    // Soft reset clears all but wake enable and path select
    if (softRst_q)
    begin
      sts_d  = '0;
      en_d   = '0;
      dual_d = '0;
    end
    if (regReq.req)
    begin
      rsp_d.ack = 1'b1;
      if (regReq.wr)
      begin
        case (grp)
          GRP_CTL:
          begin
            case (regReq.addr)
              OFS_PWCTL:
              begin
                softRst_d = regReq.wdata[PW_SRST];
                wakeEn_d  = regReq.wdata[PW_WAKE];
              end
              OFS_MSTSET:
              begin
                wrRst_d = regReq.wdata[MS_WRST];
                rdRst_d = regReq.wdata[MS_RRST];
              end
              OFS_INTSTS: sts_d = sts_d & ~regReq.wdata[IRQ_N-1:0];
              OFS_INTENB: en_d = regReq.wdata[IRQ_N-1:0];
              default: ;
            endcase
          end
          GRP_EPCFG:
          begin
            if (epOk)
            begin
              busSel_d[epIdx] = regReq.wdata[EP_BUSSEL];
              dual_d[epIdx]   = regReq.wdata[EP_DUAL];
            end
          end
          default: ;
        endcase
      end
      else
      begin
        case (grp)
          GRP_CTL:
          begin
            case (regReq.addr)
              OFS_PWCTL:
              begin
                rsp_d.rdata[PW_WAKE] = wakeEn_q;
                rsp_d.rdata[PW_SUSP] = sync2_q[SY_SUSP];
                rsp_d.rdata[PW_VBUS] = sync2_q[SY_PWR];
              end
              OFS_INTSTS: rsp_d.rdata[IRQ_N-1:0] = sts_q;
              OFS_INTENB: rsp_d.rdata[IRQ_N-1:0] = en_q;
              default: ;
            endcase
          end
          GRP_EPCFG:
          begin
            if (epOk)
            begin
              rsp_d.rdata[EP_BUSSEL] = busSel_q[epIdx];
              rsp_d.rdata[EP_DUAL]   = dual_q[epIdx];
            end
          end
          GRP_DSZ:
          begin
            if (epOk)
              rsp_d.rdata[CNT_W-1:0] = byteCnt[epIdx];
          end
          GRP_FIFO:
          begin
            if (epOk && !busSel_q[epIdx])
              rsp_d.rdata[PORT_W-1:0] = rdWord[epIdx];
          end
          default: ;
        endcase
      end
    end
    // Direct path read data
    if (dirReq.rd && dirOk && busSel_q[dirReq.ep])
      dirRd_d = rdWord[dirReq.ep];
    // Events set status after any clear, so a set is never lost
    sts_d = sts_d | irqEvent;
    // Enabled pending status drives the main line, gated by bus clock
    mainIrq_d = |(sts_d & en_d) & sync2_q[SY_CLK];
    // Resume level and its falling edge
    resume_d = (wakeEn_q & sync2_q[SY_SUSP])
             | ~sync2_q[SY_PWR];
    resIrq_d = resume_q & ~resume_d;
  end

  // State registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sts_q     <= '0;
      en_q      <= '0;
      wakeEn_q  <= 1'b0;
      softRst_q <= 1'b0;
      wrRst_q   <= 1'b0;
      rdRst_q   <= 1'b0;
      busSel_q  <= '0;
      dual_q    <= '0;
      resume_q  <= 1'b0;
      resIrq_q  <= 1'b0;
      mainIrq_q <= 1'b0;
      rsp_q     <= '0;
      dirRd_q   <= '0;
    end
    else
    begin
      sts_q     <= sts_d;
      en_q      <= en_d;
      wakeEn_q  <= wakeEn_d;
      softRst_q <= softRst_d;
      wrRst_q   <= wrRst_d;
      rdRst_q   <= rdRst_d;
      busSel_q  <= busSel_d;
      dual_q    <= dual_d;
      resume_q  <= resume_d;
      resIrq_q  <= resIrq_d;
      mainIrq_q <= mainIrq_d;
      rsp_q     <= rsp_d;
      dirRd_q   <= dirRd_d;
    end
  end

  // Outputs: the two interrupt lines, channel reset pulses, register answer and direct read data
  assign mainEventIrq = mainIrq_q;
  assign resumeIrq    = resIrq_q;
  assign wrChanRst    = wrRst_q;
  assign rdChanRst    = rdRst_q;
  assign regRsp       = rsp_q;
  assign dirRdata     = dirRd_q;

  enable_reset_zero_a: assert property (@(posedge core_clk)
    $past(srst) && !srst |-> en_q == '0)
    else $error("enable register not zero after reset");

  masked_no_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    mainEventIrq |-> |(sts_q & en_q))
    else $error("main interrupt without enabled pending status");

  irq_follows_sts_a: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) |-> mainEventIrq ==
      (|(sts_q & en_q) && $past(sync2_q[SY_CLK])))
    else $error("main interrupt does not track status and enable");

  event_sets_sts_a: assert property (@(posedge core_clk) disable iff (srst)
    |irqEvent |=> (sts_q & $past(irqEvent)) == $past(irqEvent))
    else $error("event did not set its status bit");

  clk_stop_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    !sync2_q[SY_CLK] [*2] |=> !mainEventIrq)
    else $error("main interrupt while bus clock stopped");

  resume_fall_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    resumeIrq == $fell(resume_q))
    else $error("resume interrupt not on resume falling edge");

  power_loss_wake_a: assert property (@(posedge core_clk) disable iff (srst)
    !sync2_q[SY_PWR] |=> resume_q)
    else $error("resume not raised on bus power loss");

  wake_release_a: assert property (@(posedge core_clk) disable iff (srst)
    wakeEn_q && sync2_q[SY_SUSP] |=> resume_q)
    else $error("resume not raised on suspend release");

  fifo_upper_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    $past(regReq.req && !regReq.wr && grp == GRP_FIFO) |->
      regRsp.rdata[DATA_W-1:PORT_W] == '0)
    else $error("upper half of FIFO read not zero");

  chan_rst_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    (wrChanRst || rdChanRst) |-> $stable(en_q) && $stable(busSel_q))
    else $error("channel reset disturbed bridge registers");

  soft_rst_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    softRst_q && !regReq.req |=> en_q == '0 && $stable(wakeEn_q)
      && $stable(busSel_q))
    else $error("soft reset cleared or kept the wrong bits");

endmodule : udb_bridge

// *** shared/udb_pkg.sv ***
// Shared constants and carriers for the USB bus bridge.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
package udb_pkg;

  // Clock rate of core_clk
  localparam int CLK_HZ = 10_000_000;

  // Widths and default sizes
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int PORT_W       = 16;
  localparam int CNT_W        = 11;
  localparam int EP_W         = 3;
  localparam int NUM_EP_DEF   = 7;
  localparam int IRQ_N_DEF    = 8;
  localparam int FIFO_DEPTH_DEF = 128;
  localparam int MAX_PKT_DEF  = 64;
  localparam int BYTES_PER_ACC = 2;

  // Register offsets of the control group
  localparam logic [ADDR_W-1:0] OFS_PWCTL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MSTSET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INTSTS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INTENB = 8'h0C;

  // Address groups (addr[7:6]); endpoint index in addr[4:2]
  localparam logic [1:0] GRP_CTL   = 2'h0;
  localparam logic [1:0] GRP_EPCFG = 2'h1;
  localparam logic [1:0] GRP_DSZ   = 2'h2;
  localparam logic [1:0] GRP_FIFO  = 2'h3;
  localparam int GRP_MSB = 7;
  localparam int GRP_LSB = 6;
  localparam int EPI_MSB = 4;
  localparam int EPI_LSB = 2;

  // Field positions
  localparam int PW_SRST   = 0;
  localparam int PW_WAKE   = 1;
  localparam int PW_SUSP   = 2;
  localparam int PW_VBUS   = 3;
  localparam int MS_WRST   = 0;
  localparam int MS_RRST   = 1;
  localparam int EP_BUSSEL = 0;
  localparam int EP_DUAL   = 1;

  // Synchroniser lanes and their reset levels
  localparam int SY_CLK  = 0;
  localparam int SY_SUSP = 1;
  localparam int SY_PWR  = 2;
  localparam logic [2:0] SYNC_RST = 3'h5;

  // Register port request and answer
  typedef struct packed {
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } udb_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } udb_rsp_s;

  // Direct FIFO path used by master transfers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [EP_W-1:0]   ep;
    logic [PORT_W-1:0] wdata;
  } udb_dir_s;

endpackage : udb_pkg

// *** design/udb_ep_buf.sv ***
// One endpoint buffer: byte storage with a 16-bit access port.
// Assumes DEPTH is a power of two and at most one access per cycle.
`timescale 1ns/1ns
module udb_ep_buf
  import udb_pkg::*;
#(
  parameter int DEPTH   = FIFO_DEPTH_DEF,
  parameter int MAX_PKT = MAX_PKT_DEF
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              clr,
  // Mode
  input  wire logic              dualMode,
  // Access port
  input  wire logic              wrEn,
  input  wire logic [PORT_W-1:0] wrData,
  input  wire logic              rdEn,
  output logic      [PORT_W-1:0] rdData,
  // Byte count seen by software
  output logic      [CNT_W-1:0]  byteCount
);

  localparam int AW = $clog2(DEPTH);

  logic [7:0]       mem_q [DEPTH];
  logic [7:0]       mem_d [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             put, take, two;

  // Access qualification
  assign two  = cnt_q >= CNT_W'(BYTES_PER_ACC);
  assign put  = wrEn && (int'(cnt_q) + BYTES_PER_ACC <= DEPTH);
  assign take = rdEn && (cnt_q != '0);

  // Next pointers, count and storage
  always_comb
  begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (clr)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
    else
    begin
      if (put)
      begin
        mem_d[wp_q]          = wrData[7:0];
        mem_d[wp_q + AW'(1)] = wrData[15:8];
        wp_d  = wp_q + AW'(BYTES_PER_ACC);
        cnt_d = cnt_d + CNT_W'(BYTES_PER_ACC);
      end
      if (take)
      begin
        rp_d  = rp_q + (two ? AW'(BYTES_PER_ACC) : AW'(1));
        cnt_d = cnt_d - (two ? CNT_W'(BYTES_PER_ACC) : CNT_W'(1));
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk)
  begin
    mem_q <= mem_d;
    if (srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Head word; an odd last byte returns with a zero upper byte
  assign rdData = (cnt_q == '0) ? '0 :
                  {two ? mem_q[rp_q + AW'(1)] : 8'h00, mem_q[rp_q]};

  // Valid bytes; dual mode shows only the packet read first
  assign byteCount = (dualMode && cnt_q > CNT_W'(MAX_PKT)) ?
                     CNT_W'(MAX_PKT) : cnt_q;

  count_on_write_a: assert property (@(posedge core_clk) disable iff (srst)
    put && !take && !clr |=> cnt_q == $past(cnt_q) + CNT_W'(BYTES_PER_ACC))
    else $error("byte count did not grow by one access");

  dual_count_cap_a: assert property (@(posedge core_clk) disable iff (srst)
    dualMode |-> byteCount <= CNT_W'(MAX_PKT) && byteCount <= cnt_q)
    else $error("dual mode byte count exceeds one packet");

endmodule : udb_ep_buf

// *** tb/udb_core_model.sv ***
// Model of the device core side: event lines, pins and direct master path.
// Assumes core_clk comes from the bench; every change lands after a rise.
`timescale 1ns/1ns
module udb_core_model
  import udb_pkg::*;
#(
  parameter int IRQ_N = IRQ_N_DEF
)(
  // Clock
  input  wire logic         core_clk,
  // Events and pins
  output logic [IRQ_N-1:0]  irqEvent,
  output logic              busClkOn,
  output logic              suspendRelease,
  output logic              busPowerPresent,
  // Direct buffer path
  output udb_pkg::udb_dir_s dirReq
);
  // Idle levels: clock running, suspended, bus powered
  initial
  begin
    irqEvent = '0;
    busClkOn = 1'b1;
    suspendRelease = 1'b0;
    busPowerPresent = 1'b1;
    dirReq = '0;
  end

  // One-cycle event on a single source
  task automatic pulse(input int idx);
    @(posedge core_clk);
    irqEvent <= IRQ_N'(1) << idx;
    @(posedge core_clk);
    irqEvent <= '0;
  endtask : pulse

  // New pin levels
  task automatic pins(input logic clkOn, input logic susp, input logic pwr);
    @(posedge core_clk);
    busClkOn <= clkOn;
    suspendRelease <= susp;
    busPowerPresent <= pwr;
  endtask : pins

  // One direct access; released data is inverted so it cannot linger
  task automatic dir(input logic wr, input logic [EP_W-1:0] ep,
                     input logic [PORT_W-1:0] d);
    @(posedge core_clk);
    dirReq <= '{wr: wr, rd: !wr, ep: ep, wdata: d};
    @(posedge core_clk);
    dirReq <= '{wr: 1'b0, rd: 1'b0, ep: ep, wdata: ~d};
  endtask : dir
endmodule : udb_core_model

// *** tb/udb_bridge_tb_top.sv ***
// Self-checking bench for the bridge through its register port.
// Assumes the core model drives events, pins and the direct path.
`timescale 1ns/1ns
module udb_bridge_tb_top;
  import udb_pkg::*;
  localparam int DEPTH = 16;
  localparam int PKT   = 8;
  logic                 core_clk;
  logic                 srst;
  udb_req_s             regReq;
  udb_rsp_s             regRsp;
  udb_dir_s             dirReq;
  logic [PORT_W-1:0]    dirRdata;
  logic [IRQ_N_DEF-1:0] irqEvent;
  logic                 busClkOn;
  logic                 suspendRelease;
  logic                 busPowerPresent;
  logic                 mainEventIrq;
  logic                 resumeIrq;
  logic                 wrChanRst;
  logic                 rdChanRst;
  logic [DATA_W-1:0]    rdWord;
  int numErrors = 0;
  int checked = 0;
  int wakeCnt = 0;
  int wrCnt = 0;
  int rdCnt = 0;

  // 10 MHz clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  udb_bridge #(.NUM_EP(NUM_EP_DEF), .IRQ_N(IRQ_N_DEF),
               .FIFO_DEPTH(DEPTH), .MAX_PKT(PKT)) uut (
    .core_clk(core_clk), .srst(srst), .regReq(regReq), .regRsp(regRsp),
    .dirReq(dirReq), .dirRdata(dirRdata), .irqEvent(irqEvent),
    .busClkOn(busClkOn), .suspendRelease(suspendRelease),
    .busPowerPresent(busPowerPresent),
    .mainEventIrq(mainEventIrq), .resumeIrq(resumeIrq),
    .wrChanRst(wrChanRst), .rdChanRst(rdChanRst));

  udb_core_model #(.IRQ_N(IRQ_N_DEF)) coreModel (
    .core_clk(core_clk), .irqEvent(irqEvent), .busClkOn(busClkOn),
    .suspendRelease(suspendRelease), .busPowerPresent(busPowerPresent),
    .dirReq(dirReq));

  // Count one-cycle pulses
  always @(posedge core_clk)
  begin
    if (resumeIrq === 1'b1) wakeCnt <= wakeCnt + 1;
    if (wrChanRst === 1'b1) wrCnt <= wrCnt + 1;
    if (rdChanRst === 1'b1) rdCnt <= rdCnt + 1;
  end

  // Verdict and end of run
  task automatic stop_test();
    $display("Mismatches %0d of %0d compares", numErrors, checked);
    if (numErrors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One register access, request shown for one edge, bounded ack wait
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    @(posedge core_clk);
    regReq <= '{req: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge core_clk);
    regReq <= '{req: 1'b0, wr: 1'b0, addr: a, wdata: ~d};
    n = 0;
    @(negedge core_clk);
    while (regRsp.ack !== 1'b1 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    if (regRsp.ack !== 1'b1)
    begin
      numErrors++;
      stop_test();
    end
    rdWord = regRsp.rdata;
  endtask : access

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    access(1'b0, a, '0);
    check(rdWord, e);
  endtask : reg_rd

  // Bounded wait for the main interrupt level, then compare
  task automatic wait_irq(input logic e, input int lim);
    int n;
    n = 0;
    while (mainEventIrq !== e && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    check({31'h0, mainEventIrq}, {31'h0, e});
    // A level that never came ends the run
    if (mainEventIrq !== e) stop_test();
  endtask : wait_irq

  // Main sequence
  initial
  begin
    regReq = '0;
    srst = 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    reg_rd(OFS_INTENB, 32'h0);
    reg_rd(OFS_INTSTS, 32'h0);
    reg_rd(8'h84, 32'h0);
    reg_rd(8'h10, 32'h0);
    // Configure, then soft reset on bus power
    reg_wr(OFS_INTENB, 32'hFF);
    reg_wr(OFS_PWCTL, 32'h2);
    reg_wr(8'h4C, 32'h1);
    reg_wr(8'h48, 32'h2);
    reg_wr(OFS_PWCTL, 32'h3);
    reg_rd(OFS_INTENB, 32'h0);
    reg_rd(OFS_PWCTL, 32'hA);
    reg_rd(8'h4C, 32'h1);
    reg_rd(8'h48, 32'h0);
    reg_wr(8'h48, 32'h2);
    // Fill single-mode buffer past full, then drain
    for (int i = 0; i < 9; i++) reg_wr(8'hC4, 32'h1100 + i);
    reg_rd(8'h84, DEPTH);
    for (int i = 0; i < 8; i++)
    begin
      reg_rd(8'hC4, 32'h1100 + i);
      reg_rd(8'h84, DEPTH - 2 * (i + 1));
    end
    reg_rd(8'hC4, 32'h0);
    // Dual mode shows the first packet only
    for (int i = 0; i < 6; i++) reg_wr(8'hC8, 32'hFFFF0000 + i);
    reg_rd(8'h88, PKT);
    for (int i = 0; i < 4; i++) reg_rd(8'hC8, i);
    reg_rd(8'h88, 4);
    // Direct path endpoint
    coreModel.dir(1'b1, 3'h3, 16'h5A5A);
    reg_rd(8'h8C, 32'h2);
    reg_rd(8'hCC, 32'h0);
    coreModel.dir(1'b0, 3'h3, 16'h0);
    repeat (2) @(negedge core_clk);
    check({16'h0, dirRdata}, 32'h5A5A);
    reg_rd(8'h8C, 32'h0);
    // Every event source, disabled then enabled
    for (int i = 0; i < IRQ_N_DEF; i++)
    begin
      coreModel.pulse(i);
      repeat (2) @(negedge core_clk);
      wait_irq(1'b0, 0);
      reg_rd(OFS_INTSTS, 32'h1 << i);
      reg_wr(OFS_INTENB, 32'h1 << i);
      wait_irq(1'b1, 2);
      reg_wr(OFS_INTSTS, 32'h1 << i);
      wait_irq(1'b0, 2);
      coreModel.pulse(i);
      wait_irq(1'b1, 4);
      reg_wr(OFS_INTSTS, 32'h1 << i);
      reg_wr(OFS_INTENB, 32'h0);
      wait_irq(1'b0, 2);
    end
    // Bus clock stopped holds the main interrupt off
    reg_wr(OFS_INTENB, 32'h1);
    coreModel.pins(1'b0, 1'b0, 1'b1);
    repeat (4) @(negedge core_clk);
    coreModel.pulse(0);
    repeat (4) @(negedge core_clk);
    wait_irq(1'b0, 0);
    reg_rd(OFS_INTSTS, 32'h1);
    coreModel.pins(1'b1, 1'b0, 1'b1);
    wait_irq(1'b1, 6);
    reg_wr(OFS_INTSTS, 32'h1);
    // Channel resets pulse alone and leave registers
    reg_wr(OFS_INTENB, 32'h5A);
    reg_wr(OFS_MSTSET, 32'h1);
    reg_wr(OFS_MSTSET, 32'h2);
    // Let the read-channel pulse reach its counter
    @(negedge core_clk);
    check(wrCnt, 1);
    check(rdCnt, 1);
    reg_rd(OFS_INTENB, 32'h5A);
    // Resume with bus clock stopped, wake enabled
    coreModel.pins(1'b0, 1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    check(wakeCnt, 0);
    coreModel.pins(1'b0, 1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    check(wakeCnt, 1);
    // Wake disabled: suspend release alone does nothing
    reg_wr(OFS_PWCTL, 32'h0);
    coreModel.pins(1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    coreModel.pins(1'b1, 1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    check(wakeCnt, 1);
    // Bus power loss and return
    coreModel.pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(negedge core_clk);
    check(wakeCnt, 1);
    coreModel.pins(1'b1, 1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    check(wakeCnt, 2);
    stop_test();
  end
endmodule : udb_bridge_tb_top
